// file: hw/ibm_pkg.sv
// Shared types and constants for the increment, branch, OR and move execution block
package ibm_pkg;

    // Datapath widths
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;
    localparam int PC_W = 11;
    localparam int TARGET_W = 9;
    localparam int STATUS_W = 8;

    // Field positions inside the instruction word
    localparam int DEST_POS = 5;
    localparam int FADDR_LSB = 0;
    localparam int LIT_LSB = 0;
    localparam int TARGET_LSB = 0;

    // Page select bits of the status register feeding the upper program counter
    localparam int PAGE_HI_POS = 6;
    localparam int PAGE_LO_POS = 5;

    // Opcode masks and match values
    localparam logic [INSTR_W-1:0] MASK_FD = 12'hFC0;
    localparam logic [INSTR_W-1:0] MASK_F = 12'hFE0;
    localparam logic [INSTR_W-1:0] MASK_BR = 12'hE00;
    localparam logic [INSTR_W-1:0] MASK_LIT = 12'hF00;
    localparam logic [INSTR_W-1:0] MASK_ALL = 12'hFFF;
    localparam logic [INSTR_W-1:0] MATCH_INC_FILE = 12'h280;
    localparam logic [INSTR_W-1:0] MATCH_INC_SKIP = 12'h3C0;
    localparam logic [INSTR_W-1:0] MATCH_IORF = 12'h100;
    localparam logic [INSTR_W-1:0] MATCH_STORE = 12'h020;
    localparam logic [INSTR_W-1:0] MATCH_BRANCH = 12'hA00;
    localparam logic [INSTR_W-1:0] MATCH_IORL = 12'hD00;
    localparam logic [INSTR_W-1:0] MATCH_NOP = 12'h000;

    // Reset values
    localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 11'h000;
    localparam logic [FADDR_W-1:0] FADDR_RST = 5'h00;

    // Operations this block executes
    typedef enum logic [2:0] {
        OP_NOP,
        OP_INCREMENT_FILE,
        OP_INCREMENT_SKIP_ON_NULL,
        OP_ABSOLUTE_BRANCH,
        OP_OR_LITERAL_ACCUM,
        OP_OR_FILE_ACCUM,
        OP_STORE_ACCUM_TO_FILE,
        OP_FOREIGN
    } ibm_op_e;

    // Decoded instruction
    typedef struct packed {
        ibm_op_e op;
        logic dest_file;
        logic [FADDR_W-1:0] faddr;
        logic [DATA_W-1:0] literal;
        logic [TARGET_W-1:0] target;
    } ibm_dec_s;

    // File register write request
    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ibm_fwr_s;

    // Zero test used by the flag logic and the skip decision
    function automatic logic ibm_is_zero(input logic [DATA_W-1:0] value);
        return value == '0;
    endfunction : ibm_is_zero

    // Opcode match against a mask
    function automatic logic ibm_match(input logic [INSTR_W-1:0] instr, input logic [INSTR_W-1:0] mask,
                                       input logic [INSTR_W-1:0] value);
        return (instr & mask) == value;
    endfunction : ibm_match

endpackage : ibm_pkg

// file: hw/ibm_decode.sv
// Instruction decoder for the executed subset
`timescale 1ns/1ps
module ibm_decode import ibm_pkg::*; (
    // Instruction word
    input wire logic [INSTR_W-1:0] instr_in,
    // Decoded fields
    output ibm_dec_s dec_out
);

    // Priority order matters: the narrow masks are tested first
    always_comb begin
        dec_out.dest_file = instr_in[DEST_POS];
        dec_out.faddr = instr_in[FADDR_LSB +: FADDR_W];
        dec_out.literal = instr_in[LIT_LSB +: DATA_W];
        dec_out.target = instr_in[TARGET_LSB +: TARGET_W];
        if (ibm_match(instr_in, MASK_ALL, MATCH_NOP)) begin
            dec_out.op = OP_NOP;
        end else if (ibm_match(instr_in, MASK_F, MATCH_STORE)) begin
            dec_out.op = OP_STORE_ACCUM_TO_FILE;
        end else if (ibm_match(instr_in, MASK_FD, MATCH_INC_FILE)) begin
            dec_out.op = OP_INCREMENT_FILE;
        end else if (ibm_match(instr_in, MASK_FD, MATCH_INC_SKIP)) begin
            dec_out.op = OP_INCREMENT_SKIP_ON_NULL;
        end else if (ibm_match(instr_in, MASK_FD, MATCH_IORF)) begin
            dec_out.op = OP_OR_FILE_ACCUM;
        end else if (ibm_match(instr_in, MASK_LIT, MATCH_IORL)) begin
            dec_out.op = OP_OR_LITERAL_ACCUM;
        end else if (ibm_match(instr_in, MASK_BR, MATCH_BRANCH)) begin
            dec_out.op = OP_ABSOLUTE_BRANCH;
        end else begin
            dec_out.op = OP_FOREIGN;
        end
    end

endmodule : ibm_decode

// file: hw/ibm_alu.sv
// Arithmetic unit: increment, inclusive OR and pass-through of the accumulator
`timescale 1ns/1ps
module ibm_alu import ibm_pkg::*; (
    // Operation and operands
    input wire ibm_op_e op_in,
    input wire logic [DATA_W-1:0] accum_in,
    input wire logic [DATA_W-1:0] file_in,
    input wire logic [DATA_W-1:0] literal_in,
    // Result and zero test
    output logic [DATA_W-1:0] result_out,
    output logic zero_out
);

    // Increment wraps 255 to 0, which is what makes the skip fire
    always_comb begin
        case (op_in)
            OP_INCREMENT_FILE, OP_INCREMENT_SKIP_ON_NULL: result_out = DATA_W'(file_in + 1'b1);
            OP_OR_LITERAL_ACCUM: result_out = accum_in | literal_in;
            OP_OR_FILE_ACCUM: result_out = accum_in | file_in;
            OP_STORE_ACCUM_TO_FILE: result_out = accum_in;
            default: result_out = '0;
        endcase
        zero_out = ibm_is_zero(result_out);
    end

endmodule : ibm_alu

// file: hw/ibm_core.sv
// Execution stage for increment, skip, absolute branch, inclusive OR and store-to-file
//
// Behaviour
// - Increment-file adds one to the file register, updates zero, and writes the accumulator if d is 0 else the file.
// - Increment-skip-on-null adds one to file 0..31, routes by d the same way and touches no status flag.
// - When that increment gives zero, the already fetched next instruction is dropped and a no-op runs instead.
// - A skipping increment-skip-on-null takes two instruction cycles and a non-skipping one takes one.
// - The absolute branch loads its 9-bit operand 0..511 into program counter bits 8 to 0.
// - The absolute branch copies status bits 6 and 5 into program counter bits 10 and 9 as the page.
// - The absolute branch always takes two instruction cycles.
// - OR-literal ORs the accumulator with an 8-bit literal, writes the accumulator and updates zero.
// - OR-file ORs the accumulator with the file register, updates zero, and writes accumulator if d is 0 else file.
// - Store-to-file copies the accumulator into file 0..31 and leaves every status flag alone.
//
// Notes
// One instruction cycle is one clock with valid high.
// A skip or branch second cycle is the next valid word.
// Idle cycles leave that no-op slot pending.
// Zero leaves as a strobe; status lives outside.
// Foreign words only retire and raise a flag.
`timescale 1ns/1ps
module ibm_core import ibm_pkg::*; (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Instruction from fetch, one per instruction cycle
    input wire logic instr_valid_in,
    input wire logic [INSTR_W-1:0] instr_in,
    // File register read data for address instr_in[4:0], same cycle
    input wire logic [DATA_W-1:0] file_rd_data_in,
    // Status register contents, page bits used by the branch
    input wire logic [STATUS_W-1:0] status_in,
    // File register write port
    output logic file_we_out,
    output logic [FADDR_W-1:0] file_wr_addr_out,
    output logic [DATA_W-1:0] file_wr_data_out,
    // Zero flag update
    output logic zero_we_out,
    output logic zero_val_out,
    // Program counter load and fetch flush
    output logic pc_load_out,
    output logic [PC_W-1:0] pc_value_out,
    output logic flush_out,
    // Accumulator and execution status
    output logic [DATA_W-1:0] accum_out,
    output logic retire_out,
    output logic squash_out,
    output logic foreign_out
);

    // Execution states: normal, or the slot whose fetched word is replaced by a no-op
    typedef enum logic {
        ST_EXEC,
        ST_SQUASH
    } ibm_state_e;

    // Sequencer position
    ibm_state_e state;
    ibm_state_e next_state;

    // Accumulator
    logic [DATA_W-1:0] accum;
    logic [DATA_W-1:0] next_accum;

    // File write request
    ibm_fwr_s fwr;
    ibm_fwr_s next_fwr;

    // Zero strobe
    logic zero_we;
    logic next_zero_we;

    // Zero value, held
    logic zero_val;
    logic next_zero_val;

    // PC load strobe
    logic pc_load;
    logic next_pc_load;

    // PC target, held
    logic [PC_W-1:0] pc_value;
    logic [PC_W-1:0] next_pc_value;

    // Fetch flush
    logic flush;
    logic next_flush;

    // Retire pulse
    logic retire;
    logic next_retire;

    // No-op slot pulse
    logic squash;
    logic next_squash;

    // Foreign word pulse
    logic foreign;
    logic next_foreign;

    // Decode and datapath wires
    ibm_dec_s dec;
    logic [DATA_W-1:0] file_operand;
    logic [DATA_W-1:0] alu_result;
    logic alu_zero;

    // Field extraction
    ibm_decode u_decode (
        .instr_in(instr_in),
        .dec_out(dec)
    );

    // The file write leaves this block one cycle after execution, so the
    // register file has not taken it yet when the next instruction reads.
    // Forward it to avoid a stale operand on back-to-back use of one address.
    always_comb begin
        if (fwr.we && fwr.addr == dec.faddr) begin
            file_operand = fwr.data;
        end else begin
            file_operand = file_rd_data_in;
        end
    end

    // Increment, OR and move datapath
    ibm_alu u_alu (
        .op_in(dec.op),
        .accum_in(accum),
        .file_in(file_operand),
        .literal_in(dec.literal),
        .result_out(alu_result),
        .zero_out(alu_zero)
    );

    // Next-state and result routing for one instruction cycle
    always_comb begin
        // Held values keep their contents
        next_state = state;
        next_accum = accum;

        // Strobes default low
        next_fwr.we = 1'b0;
        next_fwr.addr = fwr.addr;
        next_fwr.data = fwr.data;
        next_zero_we = 1'b0;
        next_zero_val = zero_val;
        next_pc_load = 1'b0;
        next_pc_value = pc_value;
        next_flush = 1'b0;
        next_retire = 1'b0;
        next_squash = 1'b0;
        next_foreign = 1'b0;
        if (instr_valid_in) begin
            next_retire = 1'b1;
            case (state)
                ST_SQUASH: begin
                    // Word fetched behind a skip or a branch runs as a no-op
                    next_squash = 1'b1;
                    next_state = ST_EXEC;
                end
                ST_EXEC: begin
                    case (dec.op)
                        OP_INCREMENT_FILE: begin
                            // Single cycle, zero flag follows the result
                            next_zero_we = 1'b1;
                            next_zero_val = alu_zero;
                            if (dec.dest_file) begin
                                next_fwr.we = 1'b1;
                                next_fwr.addr = dec.faddr;
                                next_fwr.data = alu_result;
                            end else begin
                                next_accum = alu_result;
                            end
                        end
                        OP_INCREMENT_SKIP_ON_NULL: begin
                            // No flag update at all, only the skip decision
                            if (dec.dest_file) begin
                                next_fwr.we = 1'b1;
                                next_fwr.addr = dec.faddr;
                                next_fwr.data = alu_result;
                            end else begin
                                next_accum = alu_result;
                            end
                            if (alu_zero) begin
                                next_state = ST_SQUASH;
                            end
                        end
                        OP_ABSOLUTE_BRANCH: begin
                            // Page from status, offset from the operand
                            next_pc_load = 1'b1;
                            next_pc_value = {status_in[PAGE_HI_POS:PAGE_LO_POS], dec.target};
                            next_flush = 1'b1;
                            next_state = ST_SQUASH;
                        end

                        OP_OR_LITERAL_ACCUM: begin
                            // Accumulator only
                            next_accum = alu_result;
                            next_zero_we = 1'b1;
                            next_zero_val = alu_zero;
                        end

                        OP_OR_FILE_ACCUM: begin
                            // Routed like increment
                            next_zero_we = 1'b1;
                            next_zero_val = alu_zero;
                            if (dec.dest_file) begin
                                next_fwr.we = 1'b1;
                                next_fwr.addr = dec.faddr;
                                next_fwr.data = alu_result;
                            end else begin
                                next_accum = alu_result;
                            end
                        end
                        OP_STORE_ACCUM_TO_FILE: begin
                            // Flags untouched by design
                            next_fwr.we = 1'b1;
                            next_fwr.addr = dec.faddr;
                            next_fwr.data = alu_result;
                        end

                        OP_NOP: begin
                            // Nothing but retire
                            next_state = ST_EXEC;
                        end
                        default: begin
                            // Other opcodes belong to neighbouring units; flag them only
                            next_foreign = 1'b1;
                        end
                    endcase
                end
                default: begin
                    next_state = ST_EXEC;
                end
            endcase
        end
    end

    // Registered state, synchronous active-low reset
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            // All idle, no slot pending
            state <= ST_EXEC;
            accum <= ACCUM_RST;
            fwr.we <= 1'b0;
            fwr.addr <= FADDR_RST;
            fwr.data <= ACCUM_RST;
            zero_we <= 1'b0;
            zero_val <= 1'b0;
            pc_load <= 1'b0;
            pc_value <= PC_RST;
            flush <= 1'b0;
            retire <= 1'b0;
            squash <= 1'b0;
            foreign <= 1'b0;
        end else begin
            // Plain copy of next values
            state <= next_state;
            accum <= next_accum;
            fwr <= next_fwr;
            zero_we <= next_zero_we;
            zero_val <= next_zero_val;
            pc_load <= next_pc_load;
            pc_value <= next_pc_value;
            flush <= next_flush;
            retire <= next_retire;
            squash <= next_squash;
            foreign <= next_foreign;
        end
    end

    // Outputs straight from the flops above
    assign file_we_out = fwr.we;
    assign file_wr_addr_out = fwr.addr;
    assign file_wr_data_out = fwr.data;

    // Zero flag update
    assign zero_we_out = zero_we;
    assign zero_val_out = zero_val;

    // Branch
    assign pc_load_out = pc_load;
    assign pc_value_out = pc_value;
    assign flush_out = flush;

    // Accumulator
    assign accum_out = accum;

    // Execution status
    assign retire_out = retire;
    assign squash_out = squash;
    assign foreign_out = foreign;

endmodule : ibm_core

// file: dv/ibm_core_checker.sv
// Port-level assertion checker for the execution block
`timescale 1ns/1ps
module ibm_core_checker import ibm_pkg::*; (
    // Clock, reset and instruction side
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic instr_valid_in,
    input wire logic [INSTR_W-1:0] instr_in,
    input wire logic [DATA_W-1:0] file_rd_data_in,
    input wire logic [STATUS_W-1:0] status_in,
    // Results of the block
    input wire logic file_we_out,
    input wire logic [FADDR_W-1:0] file_wr_addr_out,
    input wire logic [DATA_W-1:0] file_wr_data_out,
    input wire logic zero_we_out,
    input wire logic zero_val_out,
    input wire logic pc_load_out,
    input wire logic [PC_W-1:0] pc_value_out,
    input wire logic flush_out,
    input wire logic [DATA_W-1:0] accum_out,
    input wire logic retire_out,
    input wire logic squash_out,
    input wire logic foreign_out
);
    logic pend;
    logic next_pend;
    logic go;
    logic [DATA_W-1:0] eff;
    logic [DATA_W-1:0] inc;
    logic is_inc, is_skp, is_iorf, is_mov, is_br, is_iorl;

    // Operand as the block sees it, last write forwarded
    always_comb begin
        eff = (file_we_out && file_wr_addr_out == instr_in[4:0]) ? file_wr_data_out : file_rd_data_in;
        inc = eff + 8'h01;
        go = instr_valid_in && !pend;
        is_inc = go && (instr_in & MASK_FD) == MATCH_INC_FILE;
        is_skp = go && (instr_in & MASK_FD) == MATCH_INC_SKIP;
        is_iorf = go && (instr_in & MASK_FD) == MATCH_IORF;
        is_mov = go && (instr_in & MASK_F) == MATCH_STORE;
        is_br = go && (instr_in & MASK_BR) == MATCH_BRANCH;
        is_iorl = go && (instr_in & MASK_LIT) == MATCH_IORL;
        next_pend = instr_valid_in ? (is_br || (is_skp && inc == 8'h00)) : pend;
    end

    // Skip slot survives idle cycles, so it is tracked here
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pend <= 1'b0;
        end else begin
            pend <= next_pend;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_inc_write:
        assert property (is_inc && instr_in[DEST_POS] |=> file_we_out && file_wr_data_out == $past(inc)
            && file_wr_addr_out == $past(instr_in[4:0])) else $error("increment file write wrong");
    a_inc_zero:
        assert property (is_inc |=> zero_we_out && zero_val_out == ($past(inc) == 8'h00))
            else $error("increment zero flag wrong");
    a_skip_flags:
        assert property (is_skp |=> !zero_we_out) else $error("skip increment touched zero flag");
    a_skip_slot:
        assert property (is_skp && inc == 8'h00 ##1 instr_valid_in |=> squash_out && !file_we_out)
            else $error("skipped word not squashed");
    a_skip_one:
        assert property (is_skp && inc != 8'h00 ##1 instr_valid_in |=> !squash_out)
            else $error("non-skipping increment squashed next word");
    a_branch_pc:
        assert property (is_br |=> pc_load_out && flush_out
            && pc_value_out == {$past(status_in[6:5]), $past(instr_in[8:0])}) else $error("branch target wrong");
    a_branch_two:
        assert property (is_br ##1 !instr_valid_in [*2] ##1 instr_valid_in |=> squash_out && !pc_load_out)
            else $error("branch second cycle missing");
    a_iorl_accum:
        assert property (is_iorl |=> zero_we_out && accum_out == ($past(accum_out) | $past(instr_in[7:0])))
            else $error("literal OR result wrong");
    a_iorf_zero:
        assert property (is_iorf |=> zero_we_out && zero_val_out == (($past(accum_out) | $past(eff)) == 8'h00))
            else $error("file OR zero flag wrong");
    a_store_copy:
        assert property (is_mov |=> file_we_out && file_wr_data_out == $past(accum_out) && !zero_we_out)
            else $error("store to file wrong");
    a_retire_once:
        assert property (instr_valid_in |=> retire_out) else $error("instruction not retired in one cycle");

    c_skip: cover property (is_skp && inc == 8'h00 ##1 instr_valid_in);
    c_branch: cover property (is_br);
    c_iorl_zero: cover property (is_iorl ##1 zero_val_out);
endmodule : ibm_core_checker

// file: dv/test_ibm_core.sv
// Self-checking testbench for the execution block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_ibm_core import ibm_pkg::*;;
    typedef struct packed {
        logic fwe; logic [FADDR_W-1:0] fa; logic [DATA_W-1:0] fd; logic zwe; logic zv;
        logic pl; logic [PC_W-1:0] pv; logic [DATA_W-1:0] acc; logic sq; logic fo;
    } ibm_exp_s;
    logic sys_clk_in, rst_n_in, instr_valid_in;
    logic [INSTR_W-1:0] instr_in;
    logic [DATA_W-1:0] file_rd_data_in;
    logic [STATUS_W-1:0] status_in;
    logic file_we_out, zero_we_out, zero_val_out, pc_load_out, flush_out, retire_out, squash_out, foreign_out;
    logic [FADDR_W-1:0] file_wr_addr_out;
    logic [DATA_W-1:0] file_wr_data_out, accum_out, acc_m;
    logic [PC_W-1:0] pc_value_out;
    logic [DATA_W-1:0] mem [32];
    logic [31:0] seed;
    logic skip_m;
    ibm_exp_s q[$];
    ibm_exp_s e_m;
    int n_errors, compares;
    logic [INSTR_W-1:0] mt [8] = '{MATCH_INC_FILE, MATCH_INC_SKIP, MATCH_IORF, MATCH_STORE, MATCH_BRANCH, MATCH_IORL,
        MATCH_NOP, 12'hC00};
    logic [INSTR_W-1:0] mk [8] = '{MASK_FD, MASK_FD, MASK_FD, MASK_F, MASK_BR, MASK_LIT, MASK_ALL, MASK_LIT};

    ibm_core ibm_core_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .file_rd_data_in(file_rd_data_in), .status_in(status_in), .file_we_out(file_we_out),
        .file_wr_addr_out(file_wr_addr_out), .file_wr_data_out(file_wr_data_out), .zero_we_out(zero_we_out),
        .zero_val_out(zero_val_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out), .flush_out(flush_out),
        .accum_out(accum_out), .retire_out(retire_out), .squash_out(squash_out), .foreign_out(foreign_out));

    // 200 MHz clock
    always #2.5 sys_clk_in = ~sys_clk_in;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Drive one word and note what it must do; the file model answers from its own copy
    task automatic issue(input logic [INSTR_W-1:0] w);
        ibm_exp_s e;
        logic [DATA_W-1:0] f;
        logic [DATA_W-1:0] r;
        @(posedge sys_clk_in);
        seed = lfsr(seed);
        f = mem[w[4:0]];
        e = '0;
        instr_valid_in <= 1'b1;
        instr_in <= w;
        file_rd_data_in <= f;
        status_in <= seed[7:0];
        if (skip_m) begin
            e.sq = 1'b1;
            skip_m = 1'b0;
        end else if ((w & MASK_FD) == MATCH_INC_FILE || (w & MASK_FD) == MATCH_INC_SKIP
                || (w & MASK_FD) == MATCH_IORF) begin
            r = ((w & MASK_FD) == MATCH_IORF) ? (acc_m | f) : f + 8'h01;
            e.zwe = (w & MASK_FD) != MATCH_INC_SKIP;
            e.zv = r == 8'h00;
            skip_m = !e.zwe && r == 8'h00;
            if (w[DEST_POS]) begin
                e.fwe = 1'b1;
                e.fa = w[4:0];
                e.fd = r;
                mem[w[4:0]] = r;
            end else begin
                acc_m = r;
            end
        end else if ((w & MASK_F) == MATCH_STORE) begin
            e.fwe = 1'b1;
            e.fa = w[4:0];
            e.fd = acc_m;
            mem[w[4:0]] = acc_m;
        end else if ((w & MASK_BR) == MATCH_BRANCH) begin
            e.pl = 1'b1;
            e.pv = {seed[6:5], w[8:0]};
            skip_m = 1'b1;
        end else if ((w & MASK_LIT) == MATCH_IORL) begin
            acc_m = acc_m | w[7:0];
            e.zwe = 1'b1;
            e.zv = acc_m == 8'h00;
        end else if (w != MATCH_NOP) begin
            e.fo = 1'b1;
        end
        e.acc = acc_m;
        q.push_back(e);
    endtask : issue

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge sys_clk_in);
            seed = lfsr(seed);
            instr_valid_in <= 1'b0;
            instr_in <= seed[11:0];
        end
    endtask : idle

    task automatic do_reset(input int n);
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        instr_valid_in <= 1'b0;
        repeat (n) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        acc_m = ACCUM_RST;
        skip_m = 1'b0;
        q.delete();
    endtask : do_reset

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Result watcher: oldest note against each retired word
    always @(negedge sys_clk_in) begin
        if (rst_n_in === 1'b1 && retire_out === 1'b1) begin
            e_m = q.pop_front();
            `CHK("squash", e_m.sq, squash_out)
            `CHK("foreign", e_m.fo, foreign_out)
            `CHK("file_we", e_m.fwe, file_we_out)
            if (e_m.fwe) `CHK("file_wr", {e_m.fa, e_m.fd}, {file_wr_addr_out, file_wr_data_out})
            `CHK("zero_we", e_m.zwe, zero_we_out)
            if (e_m.zwe) `CHK("zero_val", e_m.zv, zero_val_out)
            `CHK("pc_load", e_m.pl, pc_load_out)
            `CHK("flush", e_m.pl, flush_out)
            if (e_m.pl) `CHK("pc_value", e_m.pv, pc_value_out)
            `CHK("accum", e_m.acc, accum_out)
        end
    end

    // Watchdog sized well above the planned traffic
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_errors++;
        report_and_stop();
    end

    initial begin
        sys_clk_in = 1'b0; rst_n_in = 1'b0; instr_valid_in = 1'b0; instr_in = '0; file_rd_data_in = '0;
        status_in = '0; seed = 32'h9c26; n_errors = 0; compares = 0; acc_m = ACCUM_RST; skip_m = 1'b0;
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            mem[i] = seed[7:0];
        end
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        // Increment wraps to zero, then reads back the just-written file
        mem[3] = 8'hFF; issue(12'h2A3); issue(12'h283); issue(12'h2A3);
        $display("test increment done");
        // Skip slot back to back, across idle cycles, and the non-skipping case
        mem[4] = 8'hFF; issue(12'h3C4); issue(12'hD0F); issue(12'h3E4); idle(2); issue(12'h2A0);
        issue(12'h3E4); issue(12'hD0F);
        $display("test skip done");
        // Branch at both ends of the operand range, a branch word in the no-op slot after idle cycles
        issue(12'hBFF); issue(12'h283); issue(12'hA00); idle(2); issue(12'hA00); issue(12'hB55); issue(12'h000);
        $display("test branch done");
        // OR forms, a literal OR with a zero result, store, no-op and foreign words
        mem[9] = 8'hFF; issue(12'h289); issue(12'hD00); issue(12'h109); issue(12'h129); issue(12'h02A);
        issue(12'h12A); issue(12'hD00); issue(12'h000); issue(12'hC55); issue(12'hF00);
        $display("test or_store done");
        // Pending skip cleared by a reset in mid-run
        mem[6] = 8'hFF; issue(12'h3C6); do_reset(1);
        @(negedge sys_clk_in);
        `CHK("accum_rst", ACCUM_RST, accum_out)
        issue(12'hD01);
        $display("test reset done");
        // Random mix over every operation, with idle gaps
        repeat (400) begin
            seed = lfsr(seed);
            issue(mt[seed[10:8]] | (seed[27:16] & ~mk[seed[10:8]]));
            if (seed[3]) idle(1);
        end
        idle(3);
        `CHK("queue", 32'd0, q.size())
        $display("test random done");
        report_and_stop();
    end
endmodule : test_ibm_core

bind ibm_core ibm_core_checker ibm_core_checker_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .file_rd_data_in(file_rd_data_in), .status_in(status_in),
    .file_we_out(file_we_out), .file_wr_addr_out(file_wr_addr_out), .file_wr_data_out(file_wr_data_out),
    .zero_we_out(zero_we_out), .zero_val_out(zero_val_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
    .flush_out(flush_out), .accum_out(accum_out), .retire_out(retire_out), .squash_out(squash_out),
    .foreign_out(foreign_out));
